// file: logic/i2c_mem_pkg.sv
// Shared constants and types for the two-wire serial memory link.
// Behaviour
// - Device is slave only, never drives clock.
// - Stop is data rising while clock high.
// - Stop abandons any operation, back to idle.
// - Start is data falling while clock high.
// - Start aborts and awaits a new address.
// - Sender holds data stable while clock high.
// - Receiver pulls data low on ninth clock.
// - Missing acknowledge ends the current operation.
// - Reads continue while master acknowledges each byte.
// - Master no-acknowledge ends read, releases data.
// - First byte after start is slave address.
// - Upper nibble must equal memory type code.
// - Bits three to one match select pins.
// - Bit zero one reads, zero writes.
// - Master code 00001 enters high-speed mode.
// - Stop leaves high-speed mode.
// - Write carries two bytes of 16-bit address.
// - Address persists; reads start at current address.
// - Address increments after each byte, before acknowledge.
// - Address wraps top to zero, unlimited bytes.
// - Eight bits then acknowledge, MSB first.
// - Write protect: no acknowledge, no increment.
// - Array write after eighth bit only.
package i2c_mem_pkg;

	// ****************************************************
	// Address byte layout and codes
	// ****************************************************
	localparam int SA_TYPE_HI = 7;
	localparam int SA_TYPE_LO = 4;
	localparam int SA_SEL_HI = 3;
	localparam int SA_SEL_LO = 1;
	localparam int SA_RW = 0;
	localparam int HS_CODE_LO = 3;
	localparam logic [3:0] TYPE_CODE = 4'ha;
	localparam logic [4:0] HS_CODE = 5'h01;

	// ****************************************************
	// Sizes and reset values
	// ****************************************************
	localparam int MEM_ADDR_W = 16;
	localparam logic [15:0] ADDR_RST = 16'h0000;
	localparam logic [3:0] BYTE_BITS = 4'h8;
	localparam logic [3:0] FRAME_BITS = 4'h9;

	// ****************************************************
	// Timing
	// ****************************************************
	localparam int CLK_NS = 8;
	localparam int SCL_PHASE_NS = 500;
	localparam int SCL_PHASE_CYC = SCL_PHASE_NS / CLK_NS;
	localparam int GLITCH_CYC = 3;

	// ****************************************************
	// Master command set
	// ****************************************************
	typedef enum logic [1:0] {OP_START, OP_STOP, OP_WRITE, OP_READ} op_e;

endpackage

// file: logic/i2c_mem_if.sv
// Open-drain two-wire link joining master and memory slave.
`timescale 1ns/100ps
interface i2c_mem_if;
	logic scl_o_m;
	logic scl_oe_m;
	logic sda_o_m;
	logic sda_oe_m;
	logic sda_o_s;
	logic sda_oe_s;
	logic scl;
	logic sda;

	// Pull-ups make each wire high unless an enabled driver pulls it low.
	assign scl = !(scl_oe_m && !scl_o_m);
	assign sda = !((sda_oe_m && !sda_o_m) || (sda_oe_s && !sda_o_s));

	modport device
	(
		input scl,
		input sda,
		output sda_o_s,
		output sda_oe_s
	);
	modport host
	(
		input scl,
		input sda,
		output scl_o_m,
		output scl_oe_m,
		output sda_o_m,
		output sda_oe_m
	);
endinterface

// file: logic/i2c_mem_slave.sv
// Memory slave end: condition detect, address decode, byte array.
`timescale 1ns/100ps
module i2c_mem_slave
#(
	parameter int ADDR_W = i2c_mem_pkg::MEM_ADDR_W,
	parameter int FILT_CYC = i2c_mem_pkg::GLITCH_CYC
)
(
	// Clock and reset.
	input wire logic clk,
	input wire logic rst_b,
	// Two-wire link.
	i2c_mem_if.device link,
	// Straps.
	input wire logic [2:0] device_select_pins,
	input wire logic write_protect,
	// Status.
	output logic hs_mode,
	output logic active,
	output logic [ADDR_W-1:0] cur_addr
);
	import i2c_mem_pkg::*;

	if (ADDR_W < 1 || ADDR_W > MEM_ADDR_W || FILT_CYC < 1 || FILT_CYC > 15)
	begin : bad_param
		$error("i2c_mem_slave: unsupported parameter value");
	end

	typedef enum logic [2:0] {S_IDLE, S_RX, S_RX_ACK, S_TX, S_TX_ACK} sl_e;
	typedef enum logic [1:0] {IDX_SLAVE, IDX_AHI, IDX_ALO, IDX_DATA} idx_e;

	typedef struct packed {
		logic scl_m;
		logic scl_s;
		logic sda_m;
		logic sda_s;
		logic scl_f;
		logic sda_f;
		logic [3:0] scl_n;
		logic [3:0] sda_n;
		logic [2:0] sel_m;
		logic [2:0] sel_s;
		logic wp_m;
		logic wp_s;
		sl_e state;
		idx_e idx;
		logic [3:0] bit_cnt;
		logic [7:0] sh;
		logic [7:0] addr_hi;
		logic [ADDR_W-1:0] addr;
		logic rd;
		logic hs;
		logic sda_oe;
		logic act;
	} sl_s;

	sl_s q_ff;
	sl_s nxt_q;
	logic mem_we;
	logic [7:0] rd_byte;
	logic [7:0] mem [0:(1 << ADDR_W)-1];

	// ****************************************************
	// Glitch filter: a level is taken once stable for FILT_CYC cycles
	// ****************************************************
	function automatic logic [4:0] filt(input logic raw, input logic f,
		input logic [3:0] cnt);
		logic [3:0] lim;
		lim = 4'(FILT_CYC - 1);
		if (raw == f)
			filt = {f, 4'h0};
		else if (cnt == lim)
			filt = {raw, 4'h0};
		else
			filt = {f, cnt + 4'h1};
	endfunction
	assign rd_byte = mem[q_ff.addr];
	// ****************************************************
	// Next state
	// ****************************************************
	always_comb
	begin
		logic rise;
		logic fall;
		logic start;
		logic stop;
		logic [15:0] full_addr;
		rise = 1'b0;
		fall = 1'b0;
		start = 1'b0;
		stop = 1'b0;
		full_addr = '0;
		nxt_q = q_ff;
		mem_we = 1'b0;
		nxt_q.scl_m = link.scl;
		nxt_q.scl_s = q_ff.scl_m;
		nxt_q.sda_m = link.sda;
		nxt_q.sda_s = q_ff.sda_m;
		nxt_q.sel_m = device_select_pins;
		nxt_q.sel_s = q_ff.sel_m;
		nxt_q.wp_m = write_protect;
		nxt_q.wp_s = q_ff.wp_m;
		{nxt_q.scl_f, nxt_q.scl_n} = filt(q_ff.scl_s, q_ff.scl_f,
			q_ff.scl_n);
		{nxt_q.sda_f, nxt_q.sda_n} = filt(q_ff.sda_s, q_ff.sda_f,
			q_ff.sda_n);
		rise = !q_ff.scl_f && nxt_q.scl_f;
		fall = q_ff.scl_f && !nxt_q.scl_f;
		start = q_ff.scl_f && nxt_q.scl_f && q_ff.sda_f && !nxt_q.sda_f;
		stop = q_ff.scl_f && nxt_q.scl_f && !q_ff.sda_f && nxt_q.sda_f;
		if (stop)
		begin
			nxt_q.state = S_IDLE;
			nxt_q.sda_oe = 1'b0;
			nxt_q.hs = 1'b0;
		end
		else if (start)
		begin
			nxt_q.state = S_RX;
			nxt_q.idx = IDX_SLAVE;
			nxt_q.bit_cnt = '0;
			nxt_q.sda_oe = 1'b0;
		end
		else
		begin
			case (q_ff.state)
				S_RX:
				begin
					if (rise)
					begin
						nxt_q.sh = {q_ff.sh[6:0], q_ff.sda_f};
						nxt_q.bit_cnt = q_ff.bit_cnt + 4'h1;
					end
					else if (fall && q_ff.bit_cnt == BYTE_BITS)
					begin
						nxt_q.bit_cnt = '0;
						nxt_q.state = S_RX_ACK;
						nxt_q.sda_oe = 1'b1;
						case (q_ff.idx)
							IDX_SLAVE:
							begin
								if (q_ff.sh[SA_TYPE_HI:HS_CODE_LO] == HS_CODE)
								begin
									// Master code is never acknowledged.
									nxt_q.hs = 1'b1;
									nxt_q.state = S_IDLE;
									nxt_q.sda_oe = 1'b0;
								end
								else if (q_ff.sh[SA_TYPE_HI:SA_TYPE_LO] == TYPE_CODE
									&& q_ff.sh[SA_SEL_HI:SA_SEL_LO] == q_ff.sel_s)
								begin
									nxt_q.rd = q_ff.sh[SA_RW];
									nxt_q.idx = IDX_AHI;
								end
								else
								begin
									nxt_q.state = S_IDLE;
									nxt_q.sda_oe = 1'b0;
								end
							end
							IDX_AHI:
							begin
								nxt_q.addr_hi = q_ff.sh;
								nxt_q.idx = IDX_ALO;
							end
							IDX_ALO:
							begin
								full_addr = {q_ff.addr_hi, q_ff.sh};
								nxt_q.addr = full_addr[ADDR_W-1:0];
								nxt_q.idx = IDX_DATA;
							end
							default:
							begin
								if (q_ff.wp_s)
								begin
									nxt_q.state = S_IDLE;
									nxt_q.sda_oe = 1'b0;
								end
								else
								begin
									mem_we = 1'b1;
									nxt_q.addr = q_ff.addr + 1'b1;
								end
							end
						endcase
					end
				end
				S_RX_ACK:
				begin
					if (fall)
					begin
						nxt_q.sda_oe = 1'b0;
						nxt_q.bit_cnt = '0;
						if (q_ff.rd && q_ff.idx == IDX_AHI)
						begin
							nxt_q.sh = rd_byte;
							nxt_q.sda_oe = !rd_byte[7];
							nxt_q.state = S_TX;
						end
						else
							nxt_q.state = S_RX;
					end
				end
				S_TX:
				begin
					if (fall)
					begin
						if (q_ff.bit_cnt == BYTE_BITS - 4'h1)
						begin
							nxt_q.sda_oe = 1'b0;
							nxt_q.addr = q_ff.addr + 1'b1;
							nxt_q.state = S_TX_ACK;
						end
						else
						begin
							nxt_q.sh = {q_ff.sh[6:0], 1'b0};
							nxt_q.sda_oe = !q_ff.sh[6];
							nxt_q.bit_cnt = q_ff.bit_cnt + 4'h1;
						end
					end
				end
				S_TX_ACK:
				begin
					if (rise && q_ff.sda_f)
						nxt_q.state = S_IDLE;
					else if (fall)
					begin
						nxt_q.sh = rd_byte;
						nxt_q.sda_oe = !rd_byte[7];
						nxt_q.bit_cnt = '0;
						nxt_q.state = S_TX;
					end
				end
				default:
				begin
					// Idle: only a start wakes the slave; it never clocks.
					nxt_q.state = S_IDLE;
					nxt_q.sda_oe = 1'b0;
				end
			endcase
		end
		nxt_q.act = nxt_q.state != S_IDLE;
	end

	// ****************************************************
	// State and array registers
	// ****************************************************
	always_ff @(posedge clk)
	begin
		if (!rst_b)
		begin
			q_ff <= '0;
			q_ff.scl_m <= 1'b1;
			q_ff.scl_s <= 1'b1;
			q_ff.sda_m <= 1'b1;
			q_ff.sda_s <= 1'b1;
			q_ff.scl_f <= 1'b1;
			q_ff.sda_f <= 1'b1;
			q_ff.addr <= ADDR_RST[ADDR_W-1:0];
		end
		else
			q_ff <= nxt_q;
	end

	always_ff @(posedge clk)
	begin
		if (mem_we)
			mem[q_ff.addr] <= q_ff.sh;
	end

	assign link.sda_o_s = 1'b0;
	assign link.sda_oe_s = q_ff.sda_oe;
	assign hs_mode = q_ff.hs;
	assign active = q_ff.act;
	assign cur_addr = q_ff.addr;
endmodule

// file: logic/i2c_mem_master.sv
// Bus master end: clock divider and start, stop and byte sequencer.
`timescale 1ns/100ps
module i2c_mem_master
#(
	parameter int PHASE_CYC = i2c_mem_pkg::SCL_PHASE_CYC
)
(
	// Clock and reset.
	input wire logic clk,
	input wire logic rst_b,
	// Two-wire link.
	i2c_mem_if.host link,
	// Command port.
	input wire logic cmd_valid,
	input wire i2c_mem_pkg::op_e cmd_op,
	input wire logic [7:0] cmd_data,
	input wire logic cmd_ack,
	output logic cmd_ready,
	// Response port.
	output logic rsp_valid,
	output logic [7:0] rsp_data,
	output logic rsp_nack
);
	import i2c_mem_pkg::*;

	if (PHASE_CYC < 8 || PHASE_CYC > 65535)
	begin : bad_param
		$error("i2c_mem_master: unsupported PHASE_CYC");
	end

	typedef enum logic [1:0] {M_IDLE, M_START, M_STOP, M_BIT} ms_e;

	typedef struct packed {
		logic sda_m;
		logic sda_s;
		ms_e state;
		logic [15:0] tick;
		logic [1:0] phase;
		logic [3:0] bit_cnt;
		logic [8:0] sh;
		logic scl_oe;
		logic sda_oe;
		logic ready;
		logic rsp_v;
		logic [7:0] rsp_d;
		logic rsp_n;
	} ms_s;

	ms_s q_ff;
	ms_s nxt_q;

	// ****************************************************
	// Next state
	// ****************************************************
	always_comb
	begin
		logic tk;
		tk = 1'b0;
		nxt_q = q_ff;
		nxt_q.rsp_v = 1'b0;
		nxt_q.sda_m = link.sda;
		nxt_q.sda_s = q_ff.sda_m;
		tk = q_ff.tick == 16'(PHASE_CYC - 1);
		if (q_ff.state != M_IDLE)
		begin
			nxt_q.tick = tk ? 16'h0000 : q_ff.tick + 16'h0001;
			if (tk)
				nxt_q.phase = q_ff.phase + 2'h1;
		end
		case (q_ff.state)
			M_IDLE:
			begin
				if (cmd_valid && q_ff.ready)
				begin
					nxt_q.ready = 1'b0;
					nxt_q.tick = '0;
					nxt_q.phase = '0;
					nxt_q.bit_cnt = '0;
					case (cmd_op)
						OP_START:
						begin
							nxt_q.sda_oe = 1'b0;
							nxt_q.state = M_START;
						end
						OP_STOP:
						begin
							nxt_q.sda_oe = 1'b1;
							nxt_q.state = M_STOP;
						end
						OP_WRITE:
						begin
							// Ninth bit released for the slave's answer.
							nxt_q.sh = {cmd_data, 1'b1};
							nxt_q.state = M_BIT;
						end
						default:
						begin
							nxt_q.sh = {8'hff, !cmd_ack};
							nxt_q.state = M_BIT;
						end
					endcase
				end
			end
			M_START:
			begin
				if (tk)
				begin
					case (q_ff.phase)
						2'h0: nxt_q.scl_oe = 1'b0;
						2'h1: nxt_q.sda_oe = 1'b1;
						default:
						begin
							nxt_q.scl_oe = 1'b1;
							nxt_q.state = M_IDLE;
							nxt_q.ready = 1'b1;
							nxt_q.rsp_v = 1'b1;
						end
					endcase
				end
			end
			M_STOP:
			begin
				if (tk)
				begin
					if (q_ff.phase == 2'h0)
						nxt_q.scl_oe = 1'b0;
					else
					begin
						nxt_q.sda_oe = 1'b0;
						nxt_q.state = M_IDLE;
						nxt_q.ready = 1'b1;
						nxt_q.rsp_v = 1'b1;
					end
				end
			end
			default:
			begin
				if (tk)
				begin
					case (q_ff.phase)
						// Data changes only mid-low, never near a clock edge.
						2'h0: nxt_q.sda_oe = !q_ff.sh[8];
						2'h1: nxt_q.scl_oe = 1'b0;
						default:
						begin
							nxt_q.scl_oe = 1'b1;
							nxt_q.phase = '0;
							nxt_q.sh = {q_ff.sh[7:0], q_ff.sda_s};
							nxt_q.bit_cnt = q_ff.bit_cnt + 4'h1;
							if (q_ff.bit_cnt == FRAME_BITS - 4'h1)
							begin
								nxt_q.state = M_IDLE;
								nxt_q.ready = 1'b1;
								nxt_q.rsp_v = 1'b1;
								nxt_q.rsp_d = q_ff.sh[7:0];
								nxt_q.rsp_n = q_ff.sda_s;
							end
						end
					endcase
				end
			end
		endcase
	end

	// ****************************************************
	// State register
	// ****************************************************
	always_ff @(posedge clk)
	begin
		if (!rst_b)
		begin
			q_ff <= '0;
			q_ff.sda_m <= 1'b1;
			q_ff.sda_s <= 1'b1;
			q_ff.ready <= 1'b1;
		end
		else
			q_ff <= nxt_q;
	end

	assign link.scl_o_m = 1'b0;
	assign link.scl_oe_m = q_ff.scl_oe;
	assign link.sda_o_m = 1'b0;
	assign link.sda_oe_m = q_ff.sda_oe;
	assign cmd_ready = q_ff.ready;
	assign rsp_valid = q_ff.rsp_v;
	assign rsp_data = q_ff.rsp_d;
	assign rsp_nack = q_ff.rsp_n;
endmodule

// file: tb/i2c_mem_asserts.sv
// Concurrent checks on the link wires and slave status.
`timescale 1ns/100ps
module i2c_mem_asserts
(
	// Clock and reset.
	input wire logic clk,
	input wire logic rst_b,
	// Link.
	input wire logic scl,
	input wire logic sda,
	input wire logic sda_oe_s,
	// Slave status.
	input wire logic hs_mode,
	input wire logic active,
	input wire logic [15:0] cur_addr
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_b);

	sequence s_start;
		scl && $past(scl) && $fell(sda);
	endsequence
	sequence s_stop;
		scl && $past(scl) && $rose(sda);
	endsequence

	property p_stop_idle;
		s_stop |-> ##[1:12] !active;
	endproperty
	a_stop_idle: assert property (p_stop_idle)
		else $error("Slave busy after stop.");
	property p_stop_hs;
		s_stop |-> ##[1:12] !hs_mode;
	endproperty
	a_stop_hs: assert property (p_stop_hs)
		else $error("High speed kept after stop.");
	property p_hs_fall;
		$fell(hs_mode) |-> scl;
	endproperty
	a_hs_fall: assert property (p_hs_fall)
		else $error("High speed left without stop.");
	property p_start_active;
		s_start |-> ##[1:12] active;
	endproperty
	a_start_active: assert property (p_start_active)
		else $error("Start not taken.");
	property p_start_release;
		s_start |-> !sda_oe_s [*8];
	endproperty
	a_start_release: assert property (p_start_release)
		else $error("Slave drives data after start.");
	property p_oe_scl_low;
		$changed(sda_oe_s) |-> !scl;
	endproperty
	a_oe_scl_low: assert property (p_oe_scl_low)
		else $error("Slave data changed with clock high.");
	property p_oe_hold;
		$rose(sda_oe_s) |-> sda_oe_s [*8];
	endproperty
	a_oe_hold: assert property (p_oe_hold)
		else $error("Slave drive too short.");
	property p_addr_scl_low;
		$changed(cur_addr) |-> !scl;
	endproperty
	a_addr_scl_low: assert property (p_addr_scl_low)
		else $error("Address moved with clock high.");
	property p_hs_rise;
		$rose(hs_mode) |-> !sda_oe_s;
	endproperty
	a_hs_rise: assert property (p_hs_rise)
		else $error("Master code acknowledged.");

	c_start: cover property (s_start);
	c_stop: cover property (s_stop);
	c_hs: cover property ($rose(hs_mode));
endmodule

// file: tb/i2c_serial_memory_slave_tb_top.sv
// Bench joining the master end and the memory slave end on one link.
`timescale 1ns/100ps
module i2c_serial_memory_slave_tb_top;
	import i2c_mem_pkg::*;
	logic clk = 1'b0;
	logic rst_b;
	logic cmd_valid, cmd_ack, cmd_ready, rsp_valid, rsp_nack;
	op_e cmd_op;
	logic [7:0] cmd_data, rsp_data;
	logic [2:0] device_select_pins, dev;
	logic write_protect, hs_mode, active;
	logic [15:0] cur_addr, addr, base;
	logic [9:0] exp_q[$];
	logic [7:0] mem[int];
	int failures = 0;
	int checks_done = 0;

	i2c_mem_if link_if();
	i2c_mem_master #(.PHASE_CYC(8)) u_i2c_mem_master
	(
		.clk(clk), .rst_b(rst_b), .link(link_if), .cmd_valid(cmd_valid),
		.cmd_op(cmd_op), .cmd_data(cmd_data), .cmd_ack(cmd_ack),
		.cmd_ready(cmd_ready), .rsp_valid(rsp_valid),
		.rsp_data(rsp_data), .rsp_nack(rsp_nack)
	);
	i2c_mem_slave u_i2c_mem_slave
	(
		.clk(clk), .rst_b(rst_b), .link(link_if),
		.device_select_pins(device_select_pins),
		.write_protect(write_protect), .hs_mode(hs_mode),
		.active(active), .cur_addr(cur_addr)
	);
	i2c_mem_asserts u_i2c_mem_asserts
	(
		.clk(clk), .rst_b(rst_b), .scl(link_if.scl), .sda(link_if.sda),
		.sda_oe_s(link_if.sda_oe_s), .hs_mode(hs_mode), .active(active),
		.cur_addr(cur_addr)
	);

	always #4 clk = ~clk;

	// ****************************************************
	// Checking and command tasks
	// ****************************************************
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp,
		input string what);
		checks_done++;
		if (seen !== exp)
		begin
			failures++;
			$display("CHECK FAILED at %0t: %s %h/%h", $time, what, seen, exp);
		end
	endtask

	task automatic conclude();
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// Response is awaited before the next command, so none is lost.
	task automatic cmd(input op_e op, input logic [7:0] d, input logic ak,
		input logic [9:0] exp);
		int n;
		@(negedge clk);
		while (cmd_ready !== 1'b1)
			@(negedge clk);
		@(posedge clk);
		cmd_valid <= 1'b1;
		cmd_op <= op;
		cmd_data <= d;
		cmd_ack <= ak;
		exp_q.push_back(exp);
		@(posedge clk);
		cmd_valid <= 1'b0;
		n = 0;
		do
		begin
			@(negedge clk);
			n++;
		end
		while (rsp_valid !== 1'b1 && n < 400);
	endtask

	task automatic start_c();
		cmd(OP_START, 8'h00, 1'b0, 10'h000);
	endtask
	// The gap keeps a following start from being filtered away.
	task automatic stop_c();
		cmd(OP_STOP, 8'h00, 1'b0, 10'h000);
		repeat (20) @(negedge clk);
		chk({link_if.scl, link_if.sda}, 16'h0003, "idle wires");
	endtask
	task automatic wr(input logic [7:0] d, input logic nk);
		cmd(OP_WRITE, d, 1'b0, {1'b1, nk, d});
	endtask
	task automatic wd(input logic [7:0] d);
		wr(d, 1'b0);
		mem[addr] = d;
		addr++;
	endtask
	task automatic set_addr(input logic [15:0] a);
		start_c();
		wr({4'ha, dev, 1'b0}, 1'b0);
		wr(a[15:8], 1'b0);
		wr(a[7:0], 1'b0);
		addr = a;
	endtask
	task automatic rd_seq(input int n);
		start_c();
		wr({4'ha, dev, 1'b1}, 1'b0);
		for (int i = 1; i <= n; i++)
		begin
			cmd(OP_READ, 8'hff, i < n, {1'b1, 1'(i == n), mem[addr]});
			addr++;
		end
		stop_c();
	endtask

	always @(negedge clk)
		if (rsp_valid === 1'b1)
			if (exp_q.size() == 0)
				chk(16'h0001, 16'h0000, "extra response");
			else if (exp_q[0][9])
				chk({1'b1, rsp_nack, rsp_data}, exp_q.pop_front(), "rsp");
			else
				void'(exp_q.pop_front());

	initial
	begin
		#(8 * 60000);
		failures++;
		conclude();
	end

	initial
	begin
		rst_b = 1'b0;
		cmd_valid = 1'b0;
		cmd_op = OP_START;
		cmd_data = 8'h00;
		cmd_ack = 1'b0;
		device_select_pins = 3'h0;
		write_protect = 1'b0;
		void'($urandom(32'h08b8_f0c0));
		dev = 3'($urandom);
		base = 16'($urandom_range(16'hff00));
		repeat (16) @(posedge clk);
		rst_b <= 1'b1;
		device_select_pins <= dev;
		repeat (4) @(negedge clk);
		chk({14'h0000, hs_mode, active}, 16'h0000, "reset flags");
		chk(cur_addr, ADDR_RST, "reset address");
		set_addr(base);
		for (int i = 0; i < 3; i++)
			wd(8'($urandom));
		stop_c();
		chk(cur_addr, base + 16'h0003, "write address");
		chk(active, 1'b0, "idle after stop");
		$display("test write done");
		set_addr(base);
		rd_seq(3);
		chk(cur_addr, base + 16'h0003, "read address");
		$display("test read done");
		set_addr(16'hffff);
		wd(8'h5a);
		wd(8'ha5);
		stop_c();
		chk(cur_addr, 16'h0001, "wrap");
		set_addr(16'hffff);
		rd_seq(2);
		$display("test wrap done");
		for (int k = 0; k < 9; k++)
		begin
			start_c();
			wr(k < 8 ? {4'ha, 3'(k), 1'b0} : {4'hb, dev, 1'b0},
				1'(k != dev));
			stop_c();
		end
		$display("test select done");
		@(posedge clk);
		write_protect <= 1'b1;
		set_addr(base);
		wr(~mem[base], 1'b1);
		stop_c();
		chk(cur_addr, base, "protected address");
		@(posedge clk);
		write_protect <= 1'b0;
		rd_seq(1);
		$display("test protect done");
		start_c();
		wr({5'h01, 3'($urandom)}, 1'b1);
		chk(hs_mode, 1'b1, "high speed");
		rd_seq(2);
		chk(hs_mode, 1'b0, "normal speed");
		$display("test high speed done");
		chk(16'(exp_q.size()), 16'h0000, "responses");
		conclude();
	end
endmodule
